// >>> hw/dcke_bank.v
// one bank state tracker with per-bank legality
`include "dcke_regs.vh"
module dcke_bank (
  input wire clk_sys_i,
  input wire rst_i,
  input wire sel_i,
  input wire pre_all_i,
  input wire exec_i,
  input wire [2:0] cmd_i,
  output reg [1:0] state_o,
  output reg illegal_o
);
  reg [2:0] cnt;
  reg [1:0] next_state;
  reg [2:0] next_cnt;

  always @* begin
    next_state = state_o;
    next_cnt = (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
    illegal_o = 1'b0;
    if (state_o == `DCKE_BK_PRECHG && cnt == 3'h0) begin
      next_state = `DCKE_BK_IDLE;
    end
    if (exec_i && (sel_i || pre_all_i)) begin
      case (cmd_i)
        `DCKE_CMD_ACT: begin
          if (state_o == `DCKE_BK_IDLE) begin
            next_state = `DCKE_BK_ACTIVE;
          end else begin
            illegal_o = 1'b1;
          end
        end
        `DCKE_CMD_RD, `DCKE_CMD_WR: begin
          if (state_o != `DCKE_BK_ACTIVE) begin
            illegal_o = 1'b1;
          end
        end
        `DCKE_CMD_PRE: begin
          // precharge to idle or precharging bank is a nop
          if (state_o == `DCKE_BK_ACTIVE) begin
            next_state = `DCKE_BK_PRECHG;
            next_cnt = `DCKE_RP_CYC;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_o <= `DCKE_BK_IDLE;
      cnt <= 3'h0;
    end else begin
      state_o <= next_state;
      cnt <= next_cnt;
    end
  end
endmodule

// >>> hw/dcke_ctrl.v
// clock-enable power state control of a four-bank ddr device
`include "dcke_regs.vh"
module dcke_ctrl (
  input wire clk_sys_i,
  input wire rst_i,
  input wire cke_i,
  input wire cs_n_i,
  input wire ras_n_i,
  input wire cas_n_i,
  input wire we_n_i,
  input wire [1:0] bank_select_bits_i,
  input wire auto_precharge_flag_i,
  output reg [2:0] power_state_o,
  output wire rx_enable_o,
  output wire cmd_exec_o,
  output reg [2:0] cmd_o,
  output reg [1:0] cmd_bank_o,
  output reg illegal_o,
  output wire all_idle_o,
  output wire [7:0] bank_state_o
);
  ////////////////////////////////////////////////////////////////////////////
  reg cke_prev;
  reg [2:0] next_ps;
  reg [3:0] rc_cnt;
  reg [3:0] next_rc;
  reg next_ill;
  wire [2:0] cmd;
  wire nop;
  wire [3:0] bank_ill;
  wire exec;
  wire [1:0] bst0, bst1, bst2, bst3;

  assign cmd = cs_n_i ? `DCKE_CMD_NOP : {ras_n_i, cas_n_i, we_n_i};
  assign nop = (cmd == `DCKE_CMD_NOP);
  // receivers wake combinationally on cke, no clock edge needed
  assign rx_enable_o = cke_i || (power_state_o != `DCKE_PS_PDOWN &&
                       power_state_o != `DCKE_PS_SREF);
  // normal decode only with cke high both cycles, outside low-power states
  assign exec = cke_prev && cke_i && (power_state_o == `DCKE_PS_NORMAL);
  assign cmd_exec_o = exec && !nop;
  assign all_idle_o = (bst0 == `DCKE_BK_IDLE) && (bst1 == `DCKE_BK_IDLE) &&
                      (bst2 == `DCKE_BK_IDLE) && (bst3 == `DCKE_BK_IDLE);
  assign bank_state_o = {bst3, bst2, bst1, bst0};

  ////////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_bank
      wire [1:0] st;
      dcke_bank u_bank (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .sel_i(bank_select_bits_i == gi),
        .pre_all_i(auto_precharge_flag_i && cmd == `DCKE_CMD_PRE),
        .exec_i(exec),
        .cmd_i(cmd),
        .state_o(st),
        .illegal_o(bank_ill[gi])
      );
    end
  endgenerate
  assign bst0 = g_bank[0].st;
  assign bst1 = g_bank[1].st;
  assign bst2 = g_bank[2].st;
  assign bst3 = g_bank[3].st;

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    next_ps = power_state_o;
    next_rc = (rc_cnt != 4'h0) ? rc_cnt - 4'h1 : 4'h0;
    next_ill = 1'b0;
    case (power_state_o)
      `DCKE_PS_NORMAL: begin
        if (cke_prev && !cke_i) begin
          if (all_idle_o) begin
            if (nop) begin
              next_ps = `DCKE_PS_PDOWN;
            end else if (cmd == `DCKE_CMD_REF && we_n_i) begin
              next_ps = `DCKE_PS_SREF;
            end else begin
              next_ill = 1'b1;
            end
          end else begin
            next_ps = `DCKE_PS_SUSPEND;
          end
        end else if (exec) begin
          // refresh and mode access need every bank idle
          next_ill = (|bank_ill) || ((cmd == `DCKE_CMD_REF || cmd == `DCKE_CMD_MRS)
                     && !all_idle_o);
        end
      end
      `DCKE_PS_PDOWN: begin
        if (cke_i) begin
          if (nop) begin
            next_ps = `DCKE_PS_NORMAL;
          end else begin
            next_ill = 1'b1;
          end
        end
      end
      `DCKE_PS_SREF: begin
        if (cke_i) begin
          if (nop) begin
            next_ps = `DCKE_PS_SREF_EXIT;
            next_rc = `DCKE_RC_CYC - 4'h1;
          end else begin
            next_ill = 1'b1;
          end
        end
      end
      `DCKE_PS_SREF_EXIT: begin
        // row cycle completes before commands are decoded again
        if (rc_cnt == 4'h0) begin
          next_ps = `DCKE_PS_NORMAL;
        end else if (!nop) begin
          next_ill = 1'b1;
        end
      end
      `DCKE_PS_SUSPEND: begin
        if (cke_i) begin
          next_ps = `DCKE_PS_NORMAL;
        end
      end
      default: begin
        next_ps = `DCKE_PS_NORMAL;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cke_prev <= 1'b0;
      power_state_o <= `DCKE_PS_NORMAL;
      rc_cnt <= 4'h0;
      illegal_o <= 1'b0;
      cmd_o <= `DCKE_CMD_NOP;
      cmd_bank_o <= 2'h0;
    end else begin
      cke_prev <= cke_i;
      power_state_o <= next_ps;
      rc_cnt <= next_rc;
      illegal_o <= next_ill;
      cmd_o <= exec ? cmd : `DCKE_CMD_NOP;
      cmd_bank_o <= bank_select_bits_i;
    end
  end
endmodule

// >>> hw/dcke_regs.vh
// constants for the clock-enable power state controller
// Contract
// - self-refresh exit on cke rise with nop, idle after row cycle time
// - cke rise re-enables input receivers without waiting for a clock edge
// - power-down exit on cke rise with nop goes straight to idle
// - cke low twice keeps low-power mode and ignores command inputs
// - low-power entry only with all banks idle; nop enters power-down, refresh self-refresh
// - cke high twice decodes commands with the normal per-bank table
// - cke fall outside idle or low-power begins clock suspend next cycle
// - cke rise during suspend ends suspension next cycle, resuming operation
// - legality judged per bank selected by bank select bits
// - normal decoding applies only when cke was high the cycle before
// - precharge to idle or precharging bank acts as nop
`ifndef DCKE_REGS_VH
`define DCKE_REGS_VH
// power states
`define DCKE_PS_NORMAL 3'h0
`define DCKE_PS_PDOWN 3'h1
`define DCKE_PS_SREF 3'h2
`define DCKE_PS_SREF_EXIT 3'h3
`define DCKE_PS_SUSPEND 3'h4
// bank states
`define DCKE_BK_IDLE 2'h0
`define DCKE_BK_ACTIVE 2'h1
`define DCKE_BK_PRECHG 2'h2
// row cycle time of 70 ns at 100 mhz, rounded up to whole cycles
`define DCKE_RC_CYC 4'h7
`define DCKE_RP_CYC 3'h2
// command codes {ras_n, cas_n, we_n}
`define DCKE_CMD_NOP 3'h7
`define DCKE_CMD_ACT 3'h3
`define DCKE_CMD_RD 3'h5
`define DCKE_CMD_WR 3'h4
`define DCKE_CMD_PRE 3'h2
`define DCKE_CMD_REF 3'h1
`define DCKE_CMD_MRS 3'h0
`endif

// >>> tb/dcke_ctrl_tb_top.sv
// self-checking bench for the clock-enable power state controller
module dcke_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] NOP = 4'h7, DES = 4'h8, ACT = 4'h3, PRE = 4'h2, REF = 4'h1;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  wire cke, cs_n, ap, rx, ill, idle, cexe;
  wire [2:0] cmd, ps, dcmd;
  wire [1:0] bank, dbank;
  wire [7:0] bst;
  int fail_count = 0;
  int total_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  dcke_host i_host (.clk_i(clk_sys_i), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .bank_o(bank),
    .ap_o(ap));
  dcke_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_select_bits_i(bank),
    .auto_precharge_flag_i(ap), .power_state_o(ps), .rx_enable_o(rx), .cmd_exec_o(cexe),
    .cmd_o(dcmd), .cmd_bank_o(dbank), .illegal_o(ill), .all_idle_o(idle), .bank_state_o(bst));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // power-down with a selected command ignored, then deselect exit
  task automatic sc_pd;
    i_host.go(1'b0, NOP, 2'h0, 1'b0);
    i_host.go(1'b0, 4'h0, 2'h0, 1'b0);
    #1 chk({5'h0, ps}, 8'h01);
    chk({7'h0, rx}, 8'h00);
    chk({7'h0, cexe}, 8'h00);
    chk({7'h0, idle}, 8'h01);
    i_host.go(1'b1, DES, 2'h0, 1'b0);
    #1 chk({5'h0, ps}, 8'h01);
    chk({7'h0, rx}, 8'h01);
    i_host.go(1'b1, NOP, 2'h0, 1'b0);
    #1 chk({5'h0, ps}, 8'h00);
  endtask
  task automatic sc_sr;
    i_host.go(1'b0, REF, 2'h0, 1'b0);
    i_host.go(1'b0, ACT, 2'h1, 1'b0);
    #1 chk({5'h0, ps}, 8'h02);
    i_host.go(1'b1, NOP, 2'h0, 1'b0);
    #1 chk(bst, 8'h00);
    i_host.go(1'b1, NOP, 2'h0, 1'b0);
    #1 chk({5'h0, ps}, 8'h03);
    repeat (6) i_host.go(1'b1, NOP, 2'h0, 1'b0);
    #1 chk({5'h0, ps}, 8'h03);
    i_host.go(1'b1, NOP, 2'h0, 1'b0);
    #1 chk({5'h0, ps}, 8'h00);
  endtask
  // banks judged one by one, then suspend with banks open
  task automatic sc_bank;
    i_host.go(1'b1, ACT, 2'h1, 1'b0);
    i_host.go(1'b1, ACT, 2'h1, 1'b0);
    i_host.go(1'b1, ACT, 2'h2, 1'b0);
    #1 chk({7'h0, ill}, 8'h01);
    i_host.go(1'b1, PRE, 2'h3, 1'b0);
    #1 chk({7'h0, ill}, 8'h00);
    chk({3'h0, dbank, dcmd}, 8'h13);
    chk({7'h0, cexe}, 8'h01);
    i_host.go(1'b1, NOP, 2'h0, 1'b0);
    #1 chk(bst, 8'h14);
    chk({7'h0, idle}, 8'h00);
    i_host.go(1'b0, NOP, 2'h0, 1'b0);
    i_host.go(1'b0, ACT, 2'h3, 1'b0);
    #1 chk({5'h0, ps}, 8'h04);
    i_host.go(1'b1, NOP, 2'h0, 1'b0);
    i_host.go(1'b1, PRE, 2'h0, 1'b1);
    #1 chk({5'h0, ps}, 8'h00);
    chk(bst, 8'h14);
    i_host.go(1'b1, NOP, 2'h0, 1'b0);
    #1 chk(bst, 8'h28);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    fail_count++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) i_host.go(1'b1, NOP, 2'h0, 1'b0);
    sc_pd();
    sc_sr();
    sc_bank();
    results();
  end
endmodule

// >>> tb/dcke_host.sv
// controller model driving the command pins, one command per clock
module dcke_host (
  input wire clk_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic [2:0] cmd_o,
  output logic [1:0] bank_o,
  output logic ap_o
);
  initial begin
    cke_o = 1'b0;
    cs_n_o = 1'b1;
    cmd_o = 3'h0;
    bank_o = 2'h0;
    ap_o = 1'b0;
  end
  // deselected command lines toggle so a stale code is never mistaken for a command
  task automatic go(input logic k, input logic [3:0] c, input logic [1:0] b, input logic a);
    @(posedge clk_i);
    cke_o <= k;
    {cs_n_o, cmd_o} <= c[3] ? {1'b1, ~cmd_o} : c;
    bank_o <= b;
    ap_o <= a;
  endtask
endmodule

// >>> tb/dcke_props.sv
// port assertions for the clock-enable power state controller
module dcke_props (
  input wire clk_sys_i,
  input wire rst_i,
  input wire cke_i,
  input wire cs_n_i,
  input wire ras_n_i,
  input wire cas_n_i,
  input wire we_n_i,
  input wire [1:0] bank_select_bits_i,
  input wire auto_precharge_flag_i,
  input wire [2:0] power_state_o,
  input wire rx_enable_o,
  input wire cmd_exec_o,
  input wire [2:0] cmd_o,
  input wire [1:0] cmd_bank_o,
  input wire illegal_o,
  input wire all_idle_o,
  input wire [7:0] bank_state_o
);
  wire [2:0] cmd = {ras_n_i, cas_n_i, we_n_i};
  wire nop = cs_n_i | (cmd == 3'h7);
  wire low = (power_state_o == 3'h1) | (power_state_o == 3'h2);
  wire fall_ok = (power_state_o == 3'h0) & all_idle_o & ~cke_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_pd_entry: assert property (!$past(rst_i) && $past(cke_i) && fall_ok && nop
    |=> power_state_o == 3'h1) else $error("power-down not entered");
  a_sr_entry: assert property (!$past(rst_i) && $past(cke_i) && fall_ok && !cs_n_i && cmd == 3'h1
    |=> power_state_o == 3'h2) else $error("self-refresh not entered");
  a_lp_hold: assert property (low && !cke_i |=> $stable(power_state_o))
    else $error("low-power state left with clock enable low");
  a_pd_exit: assert property (power_state_o == 3'h1 && cke_i && nop |=> power_state_o == 3'h0)
    else $error("power-down exit not direct");
  a_sr_exit: assert property (power_state_o == 3'h2 && cke_i && nop
    |=> (power_state_o == 3'h3) [*7] ##1 power_state_o == 3'h0) else $error("bad exit wait");
  a_rx_gate: assert property (rx_enable_o == !(low && !cke_i))
    else $error("receiver enable wrong");
  a_susp_entry: assert property (!$past(rst_i) && $past(cke_i) && !cke_i && power_state_o == 3'h0
    && !all_idle_o
    |=> power_state_o == 3'h4) else $error("suspend not entered");
  a_susp_exit: assert property (power_state_o == 3'h4 && cke_i |=> power_state_o == 3'h0)
    else $error("suspend not left");
  a_exec_gate: assert property (cmd_exec_o |-> $past(cke_i) && cke_i && power_state_o == 3'h0)
    else $error("command decoded outside normal");
endmodule
bind dcke_ctrl dcke_props i_props (.*);
